/* design/cmd_fifo.sv */
// command fifo with registered read data
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    output logic [WIDTH-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [WIDTH-1:0] m_data_r;
    logic m_valid_r;
    logic push;
    logic pop;

    assign s_ready = (count_r != DEPTH_CNT);
    assign push = s_valid && s_ready;
    // refill the output register when it is empty or being taken and a word is stored
    assign pop = (count_r != '0) && (!m_valid_r || m_ready);
    assign m_data = m_data_r;
    assign m_valid = m_valid_r;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= s_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            m_data_r <= '0;
            m_valid_r <= 1'b0;
        end else if (pop) begin
            m_data_r <= mem[rd_ptr_r];
            m_valid_r <= 1'b1;
        end else if (m_ready) begin
            m_valid_r <= 1'b0;
        end
    end
endmodule : cmd_fifo
`default_nettype wire

/* design/xcvr_host.sv */
// host controller driving a four-line bidirectional bus transceiver
// Operation
// - input and output lines may be tied
// - read strobe drives direction, bus enable select
// - memory read strobe drives direction select
// - I/O read drives direction select
`timescale 1ns/1ns
`default_nettype none
module xcvr_host
    import xcvr_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic inverting_variant,
    input wire logic bus_hold_ack,
    input wire cmd_type cmd_data,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [LINE_WIDTH-1:0] rd_data,
    output logic rd_valid,
    output logic wr_done,
    output logic busy,
    output logic select_n,
    output logic direction_select,
    output logic [LINE_WIDTH-1:0] local_input_lines,
    input wire logic [LINE_WIDTH-1:0] local_output_lines
);
    localparam logic [WAIT_WIDTH-1:0] ENABLE_WAIT = WAIT_WIDTH'(ENABLE_CYCLES);
    localparam logic [WAIT_WIDTH-1:0] READ_WAIT = WAIT_WIDTH'(ENABLE_CYCLES + SYNC_STAGES);
    localparam logic [WAIT_WIDTH-1:0] DISABLE_WAIT = WAIT_WIDTH'(DISABLE_CYCLES);

    cmd_type fifo_data;
    logic fifo_valid;
    logic fifo_take;
    state_type state_r;
    logic [WAIT_WIDTH-1:0] wait_r;
    cmd_type cur_r;
    logic select_n_r;
    logic direction_r;
    logic [LINE_WIDTH-1:0] drive_r;
    logic [LINE_WIDTH-1:0] sync1_r;
    logic [LINE_WIDTH-1:0] sync2_r;
    logic [LINE_WIDTH-1:0] rd_data_r;
    logic rd_valid_r;
    logic wr_done_r;

    cmd_fifo #(
        .WIDTH($bits(cmd_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .s_data(cmd_data),
        .s_valid(cmd_valid),
        .s_ready(cmd_ready),
        .m_data(fifo_data),
        .m_valid(fifo_valid),
        .m_ready(fifo_take)
    );

    // no new transfer while the bus is handed over
    assign fifo_take = (state_r == ST_IDLE) && fifo_valid && !bus_hold_ack;

    assign select_n = select_n_r;
    assign direction_select = direction_r;
    assign local_input_lines = drive_r;
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign wr_done = wr_done_r;
    assign busy = (state_r != ST_IDLE) || fifo_valid;

    // receive path kept apart from drive
    // output lines come from another device, so synchronise first
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= local_output_lines;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cur_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (fifo_take) begin
                        cur_r <= fifo_data;
                        state_r <= ST_TURN;
                    end
                end
                // direction settles while still deselected
                ST_TURN: begin
                    // a hold here drops the command; select never fell
                    if (bus_hold_ack) begin
                        state_r <= ST_RELEASE;
                    end else begin
                        state_r <= ST_ACTIVE;
                    end
                end
                // a combinational part only needs its enable time
                ST_ACTIVE: begin
                    if (bus_hold_ack) begin
                        state_r <= ST_RELEASE;
                    end else if (wait_r == WAIT_WIDTH'(1)) begin
                        state_r <= ST_CAPTURE;
                    end
                end
                ST_CAPTURE: begin
                    state_r <= ST_RELEASE;
                end
                // wait out the disable time before any turnaround
                ST_RELEASE: begin
                    if (wait_r <= WAIT_WIDTH'(1)) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // loaded on entry to each timed state, counted down inside it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= '0;
        end else begin
            case (state_r)
                ST_TURN: begin
                    if (bus_hold_ack) begin
                        wait_r <= DISABLE_WAIT;
                    end else if (cur_r.is_read) begin
                        // read data must also cross the synchroniser
                        wait_r <= READ_WAIT;
                    end else begin
                        wait_r <= ENABLE_WAIT;
                    end
                end
                ST_ACTIVE: begin
                    if (bus_hold_ack) begin
                        wait_r <= DISABLE_WAIT;
                    end else begin
                        wait_r <= wait_r - 1'b1;
                    end
                end
                ST_CAPTURE: begin
                    wait_r <= DISABLE_WAIT;
                end
                ST_RELEASE: begin
                    wait_r <= wait_r - 1'b1;
                end
                default: begin
                    wait_r <= wait_r;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            select_n_r <= SELECT_N_RESET;
            direction_r <= DIRECTION_RESET;
            drive_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    select_n_r <= SELECT_N_RESET;
                    if (fifo_take) begin
                        direction_r <= fifo_data.is_read ? DIR_TO_OUTPUT_LINES : DIR_TO_SYSTEM_BUS;
                        drive_r <= inverting_variant ? ~fifo_data.data : fifo_data.data;
                    end
                end
                ST_TURN: begin
                    select_n_r <= bus_hold_ack;
                end
                ST_ACTIVE: begin
                    if (bus_hold_ack) begin
                        select_n_r <= 1'b1;
                    end
                end
                ST_CAPTURE: begin
                    // pins sampled, part may float again
                    select_n_r <= 1'b1;
                end
                ST_RELEASE: begin
                    select_n_r <= 1'b1;
                end
                default: begin
                    select_n_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
            wr_done_r <= 1'b0;
        end else begin
            rd_valid_r <= 1'b0;
            wr_done_r <= 1'b0;
            if (state_r == ST_CAPTURE) begin
                if (cur_r.is_read) begin
                    rd_data_r <= inverting_variant ? ~sync2_r : sync2_r;
                    rd_valid_r <= 1'b1;
                end else begin
                    wr_done_r <= 1'b1;
                end
            end
        end
    end
endmodule : xcvr_host
`default_nettype wire

/* design/xcvr_host_pkg.sv */
// shared constants and carrier types for the transceiver host controller
package xcvr_host_pkg;
    localparam int LINE_WIDTH = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 8;
    // worst-case output enable and disable times of the transceiver
    localparam int ENABLE_TIME_NS = 65;
    localparam int DISABLE_TIME_NS = 35;
    // least times round up to whole cycles
    localparam int ENABLE_CYCLES = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISABLE_CYCLES = (DISABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam int WAIT_WIDTH = 4;
    localparam logic SELECT_N_RESET = 1'b1;
    localparam logic DIRECTION_RESET = 1'b0;
    localparam logic DIR_TO_SYSTEM_BUS = 1'b0;
    localparam logic DIR_TO_OUTPUT_LINES = 1'b1;

    typedef struct packed {
        logic is_read;
        logic [LINE_WIDTH-1:0] data;
    } cmd_type;

    typedef enum {
        ST_IDLE,
        ST_TURN,
        ST_ACTIVE,
        ST_CAPTURE,
        ST_RELEASE
    } state_type;
endpackage : xcvr_host_pkg

/* test/xcvr_host_assertions.sv */
// pin checker for the transceiver host controller
`timescale 1ns/1ns
`default_nettype none
module xcvr_host_checker
    import xcvr_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic bus_hold_ack,
    input wire logic rd_valid,
    input wire logic wr_done,
    input wire logic select_n,
    input wire logic direction_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_DIR_IDLE: assert property ($changed(direction_select) |-> select_n && $past(select_n))
        else $error("direction moved while selected");
    AST_HOLD_FLOAT: assert property (bus_hold_ack |-> ##[0:2] select_n)
        else $error("bus kept on hold");
    AST_WR_DIR: assert property (wr_done |-> !direction_select && select_n)
        else $error("write done in wrong state");
    AST_RD_DIR: assert property (rd_valid |-> direction_select && select_n)
        else $error("read done in wrong state");
    AST_GAP: assert property ($rose(select_n) |-> select_n [*5])
        else $error("turnaround too short");
    AST_DIR_SETUP: assert property ($fell(select_n) |-> $stable(direction_select) && $past(select_n, 2))
        else $error("select before direction");
    cover property (wr_done);
    cover property (rd_valid);
    cover property (bus_hold_ack && !select_n);
endmodule : xcvr_host_checker

bind xcvr_host xcvr_host_checker xcvr_host_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_hold_ack(bus_hold_ack), .rd_valid(rd_valid), .wr_done(wr_done), .select_n(select_n),
    .direction_select(direction_select));
`default_nettype wire

/* test/xcvr_host_tb_top.sv */
// self-checking bench for the transceiver host controller
`timescale 1ns/1ns
`default_nettype none
module xcvr_host_tb_top
    import xcvr_host_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic inverting_variant = 1'b0;
    logic bus_hold_ack = 1'b0;
    cmd_type cmd_data = '0;
    logic cmd_valid = 1'b0;
    logic cmd_ready, rd_valid, wr_done, busy, select_n, direction_select;
    logic [LINE_WIDTH-1:0] rd_data, local_input_lines, local_output_lines, bus_cell, ref_cell;
    int err_count = 0;
    int checks_done = 0;
    int seed = 32'h1eb0;
    int n;
    cmd_type exp_q[$];
    cmd_type c, m;
    always #(CLK_PERIOD_NS/2) sys_clk = ~sys_clk;
    xcvr_host xcvr_host_i (.sys_clk(sys_clk), .reset_n(reset_n), .inverting_variant(inverting_variant),
        .bus_hold_ack(bus_hold_ack), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done), .busy(busy), .select_n(select_n),
        .direction_select(direction_select), .local_input_lines(local_input_lines),
        .local_output_lines(local_output_lines));
    xcvr_model xcvr_model_i (.select_n(select_n), .direction_select(direction_select), .invert(inverting_variant),
        .local_input_lines(local_input_lines), .local_output_lines(local_output_lines), .bus_cell(bus_cell));
    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check4
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // leaves valid high so back-to-back commands never glitch it
    task automatic send(input cmd_type x);
        cmd_data <= x;
        cmd_valid <= 1'b1;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask : send
    task automatic settle();
        // called on a rising edge after the last command was taken
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge sys_clk);
        repeat (8) @(posedge sys_clk);
    endtask : settle
    always @(negedge sys_clk) begin
        if (reset_n === 1'b1 && (wr_done === 1'b1 || rd_valid === 1'b1)) begin
            check4({3'b000, exp_q.size() > 0}, 4'h1);
            m = exp_q.size() > 0 ? exp_q.pop_front() : 5'h1f;
            check4({3'b000, rd_valid}, {3'b000, m.is_read});
            if (m.is_read) check4(rd_data, ref_cell);
            else check4(bus_cell, m.data);
            if (!m.is_read) ref_cell = m.data;
        end
    end
    initial begin
        ref_cell = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        check4({select_n, direction_select, busy, cmd_ready}, 4'b1001);
        @(posedge sys_clk);
        bus_hold_ack <= 1'b1;
        for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
            c = cmd_type'(5'($random(seed)));
            if (i == 0) c.is_read = 1'b0;
            exp_q.push_back(c);
            send(c);
        end
        @(negedge sys_clk);
        check4({2'b00, cmd_ready, select_n}, 4'h1);
        @(posedge sys_clk);
        bus_hold_ack <= 1'b0;
        settle();
        check4(4'(exp_q.size()), 4'h0);
        // dropped write: hold arrives while the bus is driven
        send(cmd_type'(5'h0a));
        cmd_valid <= 1'b0;
        for (n = 0; n < 50 && select_n !== 1'b0; n++) @(negedge sys_clk);
        check4({3'b000, select_n}, 4'h0);
        @(posedge sys_clk);
        bus_hold_ack <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check4({3'b000, select_n}, 4'h1);
        @(posedge sys_clk);
        bus_hold_ack <= 1'b0;
        settle();
        for (int v = 0; v < 2; v++) begin
            inverting_variant <= v[0];
            @(posedge sys_clk);
            for (int i = 0; i < 24; i++) begin
                c = cmd_type'(5'($random(seed)));
                if (i == 0) c.is_read = 1'b0;
                exp_q.push_back(c);
                send(c);
            end
            settle();
            check4(4'(exp_q.size()), 4'h0);
        end
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        summarize();
    end
endmodule : xcvr_host_tb_top
`default_nettype wire

/* test/xcvr_model.sv */
// transceiver model with one memory word on the system bus
`timescale 1ns/1ns
`default_nettype none
module xcvr_model
    import xcvr_host_pkg::*;
(
    input wire logic select_n,
    input wire logic direction_select,
    input wire logic invert,
    input wire logic [LINE_WIDTH-1:0] local_input_lines,
    output logic [LINE_WIDTH-1:0] local_output_lines,
    output logic [LINE_WIDTH-1:0] bus_cell
);
    initial local_output_lines = '0;
    always @* begin
        if (!select_n && !direction_select) bus_cell = local_input_lines ^ {LINE_WIDTH{invert}};
    end
    // floating lines show no stale value
    always @(select_n, direction_select, invert, bus_cell) begin
        if (!select_n && direction_select) local_output_lines = bus_cell ^ {LINE_WIDTH{invert}};
        else local_output_lines = ~local_output_lines;
    end
endmodule : xcvr_model
`default_nettype wire
